// File: hdl/rcc_ctrl.sv
// Chosen here: the address map and the address-and-strobe port.
`timescale 1ns/1ns
`default_nettype none
`include "rcc_cfg.svh"

// What this block does
// - ten-bit signed calibration held in bits 25..16; zero means no change.
// - positive calibration adds that many time-base pulses each minute.
// - negative calibration removes pulses each minute, up to 512.
// - bit 15 set enables the clock module; clear disables it.
// - writes to the enable bit are dropped unless write unlock is set.
// - stop-in-idle bit 13 gates the bus clock off in idle mode.
// - bit 7 selects seconds clock, else alarm pulse, for the pin.
// - the pin is driven only while output enable bit 0 is set.
// - read-only bit 6 shows whether the time base is running.
// - write unlock bit 3 can be set only while unlock sequence open.
// - half-second bit 1 is read-only, cleared by a seconds write.
// - control register resets only at power-on reset.
// - unimplemented bits read zero and ignore writes.

module rcc_ctrl (
  // clock, power-on reset, clock enable
  input  wire logic                 clock_i,
  input  wire logic                 resetn_i,
  input  wire logic                 clk_en_i,
  // register port
  input  wire rcc_pkg::rcc_bus_req_t bus_i,
  output logic [31:0]               rdata_o,
  // system status
  input  wire logic                 unlock_seq_i,
  input  wire logic                 idle_i,
  // time base and calendar
  input  wire logic                 tick_i,
  input  wire logic                 minute_i,
  input  wire logic                 half_tick_i,
  input  wire logic                 sec_write_i,
  input  wire logic                 sync_i,
  input  wire logic                 seconds_clk_i,
  input  wire logic                 alarm_pulse_i,
  // module controls
  output logic                      module_on_o,
  output logic                      pb_clk_en_o,
  output logic                      tick_o,
  // output pin
  output logic                      pin_o,
  output logic                      pin_oe_o
);

  logic [9:0] cal_r;
  logic       on_r;
  logic       stop_idle_r;
  logic       sel_r;
  logic       wren_r;
  logic       oe_r;
  logic       running_r;
  logic       sync_r;
  logic       half_r;
  logic       ctrl_wr;
  logic       ctrl_rd;
  logic       gated;
  logic [31:0] ctrl_word;

  assign ctrl_wr = bus_i.wr && (bus_i.addr == `RCC_CTRL_OFS);
  assign ctrl_rd = bus_i.rd && (bus_i.addr == `RCC_CTRL_OFS);
  assign gated   = idle_i && stop_idle_r;

  // read image; unimplemented bits stay zero
  always_comb begin
    ctrl_word                         = `RCC_CTRL_RESET;
    ctrl_word[`RCC_CAL_HI:`RCC_CAL_LO] = cal_r;
    ctrl_word[`RCC_ON_BIT]            = on_r;
    ctrl_word[`RCC_STOP_IDLE_BIT]     = stop_idle_r;
    ctrl_word[`RCC_SEL_BIT]           = sel_r;
    ctrl_word[`RCC_RUN_BIT]           = running_r;
    ctrl_word[`RCC_WREN_BIT]          = wren_r;
    ctrl_word[`RCC_SYNC_BIT]          = sync_r;
    ctrl_word[`RCC_HALF_BIT]          = half_r;
    ctrl_word[`RCC_OE_BIT]            = oe_r;
  end

  // plain writable fields; only the power-on reset clears them
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cal_r       <= `RCC_CAL_ZERO;
      stop_idle_r <= 1'b0;
      sel_r       <= 1'b0;
      oe_r        <= 1'b0;
    end else if (clk_en_i && ctrl_wr) begin
      cal_r       <= bus_i.wdata[`RCC_CAL_HI:`RCC_CAL_LO];
      stop_idle_r <= bus_i.wdata[`RCC_STOP_IDLE_BIT];
      sel_r       <= bus_i.wdata[`RCC_SEL_BIT];
      oe_r        <= bus_i.wdata[`RCC_OE_BIT];
    end
  end

  // module enable, guarded by the write unlock bit
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      on_r <= 1'b0;
    end else if (clk_en_i && ctrl_wr && wren_r) begin
      on_r <= bus_i.wdata[`RCC_ON_BIT];
    end
  end

  // write unlock: set needs the open sequence, clear is always allowed
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wren_r <= 1'b0;
    end else if (clk_en_i && ctrl_wr) begin
      if (!bus_i.wdata[`RCC_WREN_BIT]) begin
        wren_r <= 1'b0;
      end else if (unlock_seq_i) begin
        wren_r <= 1'b1;
      end
    end
  end

  // half-second flag; a toggle to one beats a same-cycle clear
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      half_r <= 1'b0;
    end else if (clk_en_i) begin
      if (half_tick_i && on_r && !half_r) begin
        half_r <= 1'b1;
      end else if (sec_write_i) begin
        half_r <= 1'b0;
      end else if (half_tick_i && on_r) begin
        half_r <= 1'b0;
      end
    end
  end

  // status flags
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sync_r    <= 1'b0;
      running_r <= 1'b0;
    end else if (clk_en_i) begin
      sync_r    <= sync_i && on_r;
      running_r <= on_r && !gated;
    end
  end

  // bus clock gate and enable outputs
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pb_clk_en_o <= 1'b1;
      module_on_o <= 1'b0;
    end else if (clk_en_i) begin
      pb_clk_en_o <= !gated;
      module_on_o <= on_r;
    end
  end

  // output pin
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pin_o    <= 1'b0;
      pin_oe_o <= 1'b0;
    end else if (clk_en_i) begin
      pin_oe_o <= oe_r && on_r;
      if (oe_r && on_r) begin
        pin_o <= sel_r ? seconds_clk_i : alarm_pulse_i;
      end else begin
        pin_o <= 1'b0;
      end
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_o <= 32'h0000_0000;
    end else if (clk_en_i) begin
      if (ctrl_rd) begin
        rdata_o <= ctrl_word;
      end else begin
        rdata_o <= 32'h0000_0000;
      end
    end
  end

  // time base with per-minute drift correction
  rcc_drift_adj u_adj (
    .clock_i  (clock_i),
    .resetn_i (resetn_i),
    .clk_en_i (clk_en_i),
    .enable_i (on_r && !gated),
    .cal_i    (cal_r),
    .minute_i (minute_i),
    .tick_i   (tick_i),
    .tick_o   (tick_o)
  );

  a_cal_stored: assert property (@(posedge clock_i)
    disable iff (!resetn_i)
    (clk_en_i && ctrl_wr)
    |=> (cal_r == $past(bus_i.wdata[`RCC_CAL_HI:`RCC_CAL_LO])))
    else $error("calibration field not stored");

  a_on_locked: assert property (@(posedge clock_i)
    disable iff (!resetn_i)
    (clk_en_i && ctrl_wr && !wren_r) |=> $stable(on_r))
    else $error("enable changed while write unlock clear");

  a_on_follows: assert property (@(posedge clock_i)
    disable iff (!resetn_i)
    (clk_en_i && ctrl_wr && wren_r) ##1 clk_en_i
    |=> (module_on_o == $past(bus_i.wdata[`RCC_ON_BIT], 2)))
    else $error("module enable output wrong after write");

  a_wren_guard: assert property (@(posedge clock_i)
    disable iff (!resetn_i)
    (clk_en_i && ctrl_wr && !unlock_seq_i && !wren_r) |=> !wren_r)
    else $error("write unlock set without unlock sequence");

  a_idle_gate: assert property (@(posedge clock_i)
    disable iff (!resetn_i)
    (clk_en_i && idle_i && stop_idle_r) |=> (!pb_clk_en_o && !running_r))
    else $error("bus clock not gated in idle");

  a_pin_select: assert property (@(posedge clock_i)
    disable iff (!resetn_i)
    (clk_en_i && oe_r && on_r)
    |=> (pin_o == ($past(sel_r) ? $past(seconds_clk_i)
                                : $past(alarm_pulse_i))))
    else $error("pin shows wrong source");

  a_pin_quiet: assert property (@(posedge clock_i)
    disable iff (!resetn_i)
    (clk_en_i && !oe_r) |=> (!pin_oe_o && !pin_o))
    else $error("pin driven with output enable clear");

  a_half_clear: assert property (@(posedge clock_i)
    disable iff (!resetn_i)
    (clk_en_i && sec_write_i && !(half_tick_i && on_r)) |=> !half_r)
    else $error("half-second flag not cleared by seconds write");

  a_read_image: assert property (@(posedge clock_i)
    disable iff (!resetn_i)
    (clk_en_i && ctrl_rd)
    |=> (rdata_o[31:26] == 6'h00 && rdata_o[14] == 1'b0 &&
         rdata_o[12:8] == 5'h00 && rdata_o[5:4] == 2'h0 &&
         rdata_o[`RCC_RUN_BIT] == $past(running_r)))
    else $error("read image wrong in reserved or status bits");

  a_read_fields: assert property (@(posedge clock_i)
    disable iff (!resetn_i)
    (clk_en_i && ctrl_rd)
    |=> (rdata_o[`RCC_CAL_HI:`RCC_CAL_LO] == $past(cal_r) &&
         rdata_o[`RCC_ON_BIT] == $past(on_r) &&
         rdata_o[`RCC_STOP_IDLE_BIT] == $past(stop_idle_r) &&
         rdata_o[`RCC_SEL_BIT] == $past(sel_r) &&
         rdata_o[`RCC_OE_BIT] == $past(oe_r)))
    else $error("read image does not match stored fields");

  a_read_flags: assert property (@(posedge clock_i)
    disable iff (!resetn_i)
    (clk_en_i && ctrl_rd)
    |=> (rdata_o[`RCC_SYNC_BIT] == $past(sync_r) &&
         rdata_o[`RCC_HALF_BIT] == $past(half_r) &&
         rdata_o[`RCC_WREN_BIT] == $past(wren_r)))
    else $error("read image does not match status flags");

  a_read_idle: assert property (@(posedge clock_i)
    disable iff (!resetn_i)
    (clk_en_i && !ctrl_rd) |=> (rdata_o == 32'h0000_0000))
    else $error("read data left standing after its cycle");

  a_on_write: assert property (@(posedge clock_i)
    disable iff (!resetn_i)
    (clk_en_i && ctrl_wr && wren_r)
    |=> (on_r == $past(bus_i.wdata[`RCC_ON_BIT])))
    else $error("enable bit not taken with write unlock set");

  a_on_copy: assert property (@(posedge clock_i)
    disable iff (!resetn_i)
    clk_en_i |=> (module_on_o == $past(on_r)))
    else $error("module enable output does not follow enable bit");

  a_off_no_tick: assert property (@(posedge clock_i)
    disable iff (!resetn_i)
    (clk_en_i && !on_r) |=> !tick_o)
    else $error("time base ticked with the module disabled");

  a_wren_clear: assert property (@(posedge clock_i)
    disable iff (!resetn_i)
    (clk_en_i && ctrl_wr && !bus_i.wdata[`RCC_WREN_BIT]) |=> !wren_r)
    else $error("write unlock not cleared by a write of zero");

  a_wren_set: assert property (@(posedge clock_i)
    disable iff (!resetn_i)
    (clk_en_i && ctrl_wr && bus_i.wdata[`RCC_WREN_BIT] && unlock_seq_i)
    |=> wren_r)
    else $error("write unlock not set with sequence open");

  a_gate_free: assert property (@(posedge clock_i)
    disable iff (!resetn_i)
    (clk_en_i && !(idle_i && stop_idle_r)) |=> pb_clk_en_o)
    else $error("bus clock gated outside stop-in-idle");

  a_run_status: assert property (@(posedge clock_i)
    disable iff (!resetn_i)
    clk_en_i
    |=> (running_r == ($past(on_r) &&
                       !($past(idle_i) && $past(stop_idle_r)))))
    else $error("running status does not match time base");

  a_sync_status: assert property (@(posedge clock_i)
    disable iff (!resetn_i)
    clk_en_i |=> (sync_r == ($past(sync_i) && $past(on_r))))
    else $error("sync flag does not follow time registers");

  a_half_set: assert property (@(posedge clock_i)
    disable iff (!resetn_i)
    (clk_en_i && half_tick_i && on_r && !half_r) |=> half_r)
    else $error("half-second flag not set by its tick");

  a_half_hold: assert property (@(posedge clock_i)
    disable iff (!resetn_i)
    (clk_en_i && !sec_write_i && !(half_tick_i && on_r))
    |=> $stable(half_r))
    else $error("half-second flag changed without an event");

  a_pin_drive: assert property (@(posedge clock_i)
    disable iff (!resetn_i)
    (clk_en_i && oe_r && on_r) |=> pin_oe_o)
    else $error("pin not driven with output enable set");

  a_pin_off: assert property (@(posedge clock_i)
    disable iff (!resetn_i)
    (clk_en_i && !on_r) |=> (!pin_oe_o && !pin_o))
    else $error("pin driven with the module disabled");

  a_fields_kept: assert property (@(posedge clock_i)
    disable iff (!resetn_i)
    (clk_en_i && !ctrl_wr)
    |=> ($stable(cal_r) && $stable(on_r) && $stable(stop_idle_r) &&
         $stable(sel_r) && $stable(oe_r)))
    else $error("control field changed without a write");

  a_fields_taken: assert property (@(posedge clock_i)
    disable iff (!resetn_i)
    (clk_en_i && ctrl_wr)
    |=> (stop_idle_r == $past(bus_i.wdata[`RCC_STOP_IDLE_BIT]) &&
         sel_r == $past(bus_i.wdata[`RCC_SEL_BIT]) &&
         oe_r == $past(bus_i.wdata[`RCC_OE_BIT])))
    else $error("control bits not stored on write");

  a_freeze_out: assert property (@(posedge clock_i)
    disable iff (!resetn_i)
    !clk_en_i
    |=> ($stable(rdata_o) && $stable(module_on_o) &&
         $stable(pb_clk_en_o) && $stable(pin_o) &&
         $stable(pin_oe_o) && $stable(tick_o)))
    else $error("outputs moved with the clock enable low");

endmodule
`default_nettype wire

// File: hdl/rcc_cfg.svh
`ifndef RCC_CFG_SVH
`define RCC_CFG_SVH

// register map
`define RCC_ADDR_W        8
`define RCC_CTRL_OFS      8'h00
`define RCC_CTRL_RESET    32'h0000_0000

// control word field positions
`define RCC_CAL_HI        25
`define RCC_CAL_LO        16
`define RCC_CAL_W         10
`define RCC_ON_BIT        15
`define RCC_STOP_IDLE_BIT 13
`define RCC_SEL_BIT       7
`define RCC_RUN_BIT       6
`define RCC_WREN_BIT      3
`define RCC_SYNC_BIT      2
`define RCC_HALF_BIT      1
`define RCC_OE_BIT        0

// calibration figures
`define RCC_CAL_MAX_POS   10'h1FF
`define RCC_CAL_MAX_NEG   10'h200
`define RCC_CAL_ZERO      10'h000

`endif

// File: hdl/rcc_pkg.sv
package rcc_pkg;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } rcc_bus_req_t;

  typedef enum logic [1:0] {
    RCC_ADJ_IDLE,
    RCC_ADJ_ADD,
    RCC_ADJ_REMOVE
  } rcc_adj_state_t;

endpackage

// File: hdl/rcc_drift_adj.sv
`timescale 1ns/1ns
`default_nettype none
`include "rcc_cfg.svh"

module rcc_drift_adj (
  // clock and reset
  input  wire logic                 clock_i,
  input  wire logic                 resetn_i,
  input  wire logic                 clk_en_i,
  // control
  input  wire logic                 enable_i,
  input  wire logic [9:0]           cal_i,
  // time base
  input  wire logic                 minute_i,
  input  wire logic                 tick_i,
  output logic                      tick_o
);

  rcc_pkg::rcc_adj_state_t state_r;
  logic [9:0]              count_r;
  logic [9:0]              mag;

  // pulse count to add or remove this minute
  always_comb begin
    if (cal_i[9]) begin
      mag = (~cal_i) + 10'h001;
    end else begin
      mag = cal_i;
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_r <= rcc_pkg::RCC_ADJ_IDLE;
      count_r <= `RCC_CAL_ZERO;
    end else if (clk_en_i) begin
      if (!enable_i) begin
        state_r <= rcc_pkg::RCC_ADJ_IDLE;
        count_r <= `RCC_CAL_ZERO;
      end else if (minute_i && (cal_i != `RCC_CAL_ZERO)) begin
        count_r <= mag;
        if (cal_i[9]) begin
          state_r <= rcc_pkg::RCC_ADJ_REMOVE;
        end else begin
          state_r <= rcc_pkg::RCC_ADJ_ADD;
        end
      end else begin
        case (state_r)
          rcc_pkg::RCC_ADJ_ADD: begin
            // extra pulse only in a gap between real ticks
            if (!tick_i) begin
              count_r <= count_r - 10'h001;
              if (count_r == 10'h001) begin
                state_r <= rcc_pkg::RCC_ADJ_IDLE;
              end
            end
          end
          rcc_pkg::RCC_ADJ_REMOVE: begin
            if (tick_i) begin
              count_r <= count_r - 10'h001;
              if (count_r == 10'h001) begin
                state_r <= rcc_pkg::RCC_ADJ_IDLE;
              end
            end
          end
          default: begin
            state_r <= rcc_pkg::RCC_ADJ_IDLE;
            count_r <= `RCC_CAL_ZERO;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tick_o <= 1'b0;
    end else if (clk_en_i) begin
      case (state_r)
        rcc_pkg::RCC_ADJ_ADD:    tick_o <= enable_i;
        rcc_pkg::RCC_ADJ_REMOVE: tick_o <= 1'b0;
        default:                 tick_o <= enable_i && tick_i;
      endcase
    end
  end

  a_zero_no_adjust: assert property (@(posedge clock_i)
    disable iff (!resetn_i)
    (clk_en_i && enable_i && minute_i && cal_i == `RCC_CAL_ZERO &&
     state_r == rcc_pkg::RCC_ADJ_IDLE)
    |=> (state_r == rcc_pkg::RCC_ADJ_IDLE))
    else $error("zero calibration started an adjustment");

  a_pos_load_count: assert property (@(posedge clock_i)
    disable iff (!resetn_i)
    (clk_en_i && enable_i && minute_i && !cal_i[9] &&
     cal_i != `RCC_CAL_ZERO)
    |=> (count_r == $past(cal_i) && state_r == rcc_pkg::RCC_ADJ_ADD))
    else $error("positive calibration loaded wrong count");

  a_neg_load_count: assert property (@(posedge clock_i)
    disable iff (!resetn_i)
    (clk_en_i && enable_i && minute_i && cal_i == `RCC_CAL_MAX_NEG)
    |=> (count_r == 10'h200 && state_r == rcc_pkg::RCC_ADJ_REMOVE))
    else $error("most negative calibration not 512 pulses");

  a_remove_swallows: assert property (@(posedge clock_i)
    disable iff (!resetn_i)
    (clk_en_i && state_r == rcc_pkg::RCC_ADJ_REMOVE) |=> !tick_o)
    else $error("tick passed while removing pulses");

endmodule
`default_nettype wire

// File: verif/test_rtc_control_calibration.sv
`timescale 1ns/1ns
`default_nettype none

module test_rtc_control_calibration;

  logic                  clock_i;
  logic                  resetn_i;
  logic                  clk_en_i;
  rcc_pkg::rcc_bus_req_t bus_i;
  logic [31:0]           rdata_o;
  logic                  unlock_seq_i;
  logic                  idle_i;
  logic                  tick_i;
  logic                  minute_i;
  logic                  half_tick_i;
  logic                  sec_write_i;
  logic                  sync_i;
  logic                  seconds_clk_i;
  logic                  alarm_pulse_i;
  logic                  module_on_o;
  logic                  pb_clk_en_o;
  logic                  tick_o;
  logic                  pin_o;
  logic                  pin_oe_o;
  int                    mismatches;
  int                    cmp_count;
  logic [31:0]           v;

  rcc_ctrl dut (
    .clock_i       (clock_i),
    .resetn_i      (resetn_i),
    .clk_en_i      (clk_en_i),
    .bus_i         (bus_i),
    .rdata_o       (rdata_o),
    .unlock_seq_i  (unlock_seq_i),
    .idle_i        (idle_i),
    .tick_i        (tick_i),
    .minute_i      (minute_i),
    .half_tick_i   (half_tick_i),
    .sec_write_i   (sec_write_i),
    .sync_i        (sync_i),
    .seconds_clk_i (seconds_clk_i),
    .alarm_pulse_i (alarm_pulse_i),
    .module_on_o   (module_on_o),
    .pb_clk_en_o   (pb_clk_en_o),
    .tick_o        (tick_o),
    .pin_o         (pin_o),
    .pin_oe_o      (pin_oe_o)
  );

  initial begin
    clock_i = 1'b0;
    forever #10 clock_i = ~clock_i;
  end

  task automatic test_done();
    if (mismatches == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clock_i);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_i);
    bus_i.addr  <= a;
    bus_i.wdata <= d;
    bus_i.wr    <= 1'b1;
    @(posedge clock_i);
    bus_i.wr    <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock_i);
    bus_i.addr <= a;
    bus_i.rd   <= 1'b1;
    @(posedge clock_i);
    bus_i.rd   <= 1'b0;
    #1 d = rdata_o;
    @(posedge clock_i);
  endtask

  task automatic t_reset();
    rd(8'h00, v);
    chk("reset word", 32'h0000_0000, v);
    chk("bus clock enable", 32'h0000_0001, {31'h0, pb_clk_en_o});
  endtask

  task automatic t_lock();
    wr(8'h00, 32'h0000_8008);
    cyc(2);
    rd(8'h00, v);
    chk("locked write", 32'h0000_0000, v);
    unlock_seq_i <= 1'b1;
    wr(8'h00, 32'h0000_0008);
    wr(8'h00, 32'hFFFF_FFFF);
    cyc(3);
    rd(8'h00, v);
    chk("all ones write", 32'h03FF_A0C9, v);
    chk("module on", 32'h0000_0001, {31'h0, module_on_o});
    rd(8'h04, v);
    chk("unmapped read", 32'h0000_0000, v);
    wr(8'h04, 32'h0000_0000);
    wr(8'h00, 32'h0000_0008);
    cyc(3);
    chk("module off", 32'h0000_0000, {31'h0, module_on_o});
    rd(8'h00, v);
    chk("off word", 32'h0000_0008, v);
  endtask

  task automatic t_idle();
    wr(8'h00, 32'h0000_A008);
    idle_i <= 1'b1;
    cyc(3);
    chk("idle gated", 32'h0000_0000, {31'h0, pb_clk_en_o});
    rd(8'h00, v);
    chk("idle running", 32'h0000_0000, {31'h0, v[6]});
    wr(8'h00, 32'h0000_8008);
    cyc(3);
    chk("idle no stop", 32'h0000_0001, {31'h0, pb_clk_en_o});
    idle_i <= 1'b0;
  endtask

  task automatic pin_case(input logic [31:0] w, input logic s,
                          input logic a, input logic [1:0] exp);
    seconds_clk_i <= s;
    alarm_pulse_i <= a;
    wr(8'h00, w);
    cyc(3);
    chk("pin state", {30'h0, exp}, {30'h0, pin_oe_o, pin_o});
  endtask

  task automatic t_pin();
    pin_case(32'h0000_8089, 1'b1, 1'b0, 2'b11);
    pin_case(32'h0000_8089, 1'b0, 1'b1, 2'b10);
    pin_case(32'h0000_8009, 1'b0, 1'b1, 2'b11);
    pin_case(32'h0000_8009, 1'b1, 1'b0, 2'b10);
    pin_case(32'h0000_8088, 1'b1, 1'b1, 2'b00);
  endtask

  task automatic t_flags();
    wr(8'h00, 32'h0000_8008);
    @(posedge clock_i);
    half_tick_i <= 1'b1;
    @(posedge clock_i);
    half_tick_i <= 1'b0;
    cyc(2);
    rd(8'h00, v);
    chk("half flag set", 32'h0000_0001, {31'h0, v[1]});
    wr(8'h00, 32'h0000_8008);
    rd(8'h00, v);
    chk("half flag kept", 32'h0000_0001, {31'h0, v[1]});
    @(posedge clock_i);
    sec_write_i <= 1'b1;
    @(posedge clock_i);
    sec_write_i <= 1'b0;
    cyc(2);
    rd(8'h00, v);
    chk("half flag clear", 32'h0000_0000, {31'h0, v[1]});
    sync_i <= 1'b1;
    cyc(3);
    rd(8'h00, v);
    chk("sync flag", 32'h0000_0001, {31'h0, v[2]});
    sync_i <= 1'b0;
  endtask

  task automatic t_freeze();
    clk_en_i <= 1'b0;
    wr(8'h00, 32'h0000_0008);
    chk("frozen enable", 32'h0000_0001, {31'h0, module_on_o});
    clk_en_i <= 1'b1;
    cyc(3);
    chk("write while frozen", 32'h0000_0001, {31'h0, module_on_o});
  endtask

  task automatic t_drift(input logic [9:0] cal, input int n, input int exp);
    int cnt;
    cnt = 0;
    wr(8'h00, {6'h00, cal, 16'h8008});
    cyc(2);
    @(posedge clock_i);
    minute_i <= 1'b1;
    @(posedge clock_i);
    minute_i <= 1'b0;
    for (int i = 0; i < 625; i++) begin
      @(posedge clock_i);
      tick_i <= (i < n);
      #1 if (tick_o === 1'b1) cnt++;
    end
    chk("tick count", exp, cnt);
  endtask

  initial begin
    repeat (100000) @(posedge clock_i);
    mismatches++;
    test_done();
  end

  initial begin
    mismatches    = 0;
    cmp_count     = 0;
    resetn_i      = 1'b0;
    clk_en_i      = 1'b1;
    bus_i         = '0;
    unlock_seq_i  = 1'b0;
    idle_i        = 1'b0;
    tick_i        = 1'b0;
    minute_i      = 1'b0;
    half_tick_i   = 1'b0;
    sec_write_i   = 1'b0;
    sync_i        = 1'b0;
    seconds_clk_i = 1'b0;
    alarm_pulse_i = 1'b0;
    repeat (6) @(posedge clock_i);
    resetn_i <= 1'b1;
    t_reset();
    t_lock();
    t_idle();
    t_pin();
    t_flags();
    t_freeze();
    t_drift(10'h000, 5, 5);
    t_drift(10'h001, 0, 1);
    t_drift(10'h1FF, 0, 511);
    t_drift(10'h3FF, 600, 599);
    t_drift(10'h200, 600, 88);
    test_done();
  end

endmodule

`default_nettype wire
